// ==== shared/pior_pkg.sv ====
`default_nettype none
package pior_pkg;
	// ************************************************************
	// I/O space offsets
	// ************************************************************
	localparam logic [5:0] PIOR_OFS_IRQ_FLAGS = 6'h05;
	localparam logic [5:0] PIOR_OFS_T16_MODE = 6'h06;
	localparam logic [5:0] PIOR_OFS_TA_BOUND = 6'h09;
	localparam logic [5:0] PIOR_OFS_EDGE_SEL = 6'h0C;
	localparam logic [5:0] PIOR_OFS_PA_INPUT_EN = 6'h0D;
	localparam logic [5:0] PIOR_OFS_PA_DATA = 6'h10;
	localparam logic [5:0] PIOR_OFS_PA_DIR = 6'h11;
	localparam logic [5:0] PIOR_OFS_PA_PULL_UP = 6'h12;
	localparam logic [5:0] PIOR_OFS_PA_PULL_DOWN = 6'h13;
	localparam logic [5:0] PIOR_OFS_TA_SCALER = 6'h17;
	localparam logic [5:0] PIOR_OFS_COMP_CTL = 6'h1A;
	localparam logic [5:0] PIOR_OFS_MISC = 6'h1B;
	localparam logic [5:0] PIOR_OFS_TA_CTL = 6'h1C;
	localparam logic [5:0] PIOR_OFS_TA_COUNT = 6'h1D;
	localparam logic [5:0] PIOR_OFS_COMP_SEL = 6'h1E;
	localparam logic [5:0] PIOR_OFS_TB_CTL = 6'h2C;
	localparam logic [5:0] PIOR_OFS_TB_COUNT = 6'h2D;
	localparam logic [5:0] PIOR_OFS_TB_SCALER = 6'h2E;
	localparam logic [5:0] PIOR_OFS_TB_BOUND = 6'h2F;
	localparam logic [5:0] PIOR_OFS_LPWM_LINK = 6'h33;
	// ************************************************************
	// Writable bit masks and reset values
	// ************************************************************
	localparam logic [7:0] PIOR_MASK_IRQ = 8'h15;
	localparam logic [7:0] PIOR_MASK_EDGE_SEL = 8'hD3;
	localparam logic [7:0] PIOR_MASK_PA_INPUT_EN = 8'hF9;
	localparam logic [7:0] PIOR_MASK_MISC = 8'h27;
	localparam logic [7:0] PIOR_MASK_COMP_CTL = 8'hBF;
	localparam logic [7:0] PIOR_MASK_TA_CTL = 8'hFD;
	localparam logic [7:0] PIOR_MASK_TA_SCALER = 8'h7F;
	localparam logic [7:0] PIOR_MASK_TB_CTL = 8'h71;
	localparam logic [7:0] PIOR_MASK_TB_SCALER = 8'h63;
	localparam logic [7:0] PIOR_MASK_LPWM_LINK = 8'h08;
	localparam logic [7:0] PIOR_RST_ZERO = 8'h00;
	localparam logic [7:0] PIOR_RST_PA_INPUT_EN = 8'hF9;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PIOR_IRQ_COMP = 4;
	localparam int PIOR_IRQ_T16 = 2;
	localparam int PIOR_IRQ_PIN = 0;
	localparam int PIOR_EDGE_T16_FALL = 4;
	localparam int PIOR_PIN_A = 0;
	localparam int PIOR_PIN_B = 5;
	localparam int PIOR_MISC_FAST_WAKE = 5;
	localparam int PIOR_MISC_LVR_OFF = 2;
	localparam int PIOR_COMP_RESULT = 6;
	localparam int PIOR_LPWM_FAST_DOUBLE = 3;
	// ************************************************************
	// Timing counts in slow-oscillator clocks
	// ************************************************************
	localparam logic [4:0] PIOR_WAKE_NORMAL = 5'h10;
	localparam logic [4:0] PIOR_WAKE_FAST = 5'h08;
	localparam logic [18:0] PIOR_WDT_8K = 19'h02000;
	localparam logic [18:0] PIOR_WDT_16K = 19'h04000;
	localparam logic [18:0] PIOR_WDT_64K = 19'h10000;
	localparam logic [18:0] PIOR_WDT_256K = 19'h40000;
	// ************************************************************
	// Mode encodings
	// ************************************************************
	typedef enum logic [1:0] {
		PIOR_EDGE_BOTH = 2'b00,
		PIOR_EDGE_RISE = 2'b01,
		PIOR_EDGE_FALL = 2'b10,
		PIOR_EDGE_RSVD = 2'b11
	} pior_edge_t;
	typedef enum logic [2:0] {
		PIOR_T16_STOP = 3'b000,
		PIOR_T16_SYSCLK = 3'b001,
		PIOR_T16_PA4_FALL = 3'b011,
		PIOR_T16_FAST_RC = 3'b100,
		PIOR_T16_SLOW_RC = 3'b110,
		PIOR_T16_PA0_FALL = 3'b111
	} pior_t16_clk_t;
	typedef enum logic [3:0] {
		PIOR_TA_STOP = 4'b0000,
		PIOR_TA_SYSCLK = 4'b0001,
		PIOR_TA_FAST_RC = 4'b0010,
		PIOR_TA_SLOW_RC = 4'b0100,
		PIOR_TA_COMP = 4'b0101,
		PIOR_TA_PA0_RISE = 4'b1000,
		PIOR_TA_PA0_FALL = 4'b1001,
		PIOR_TA_PA4_INV = 4'b1101
	} pior_ta_clk_t;
	typedef enum logic [2:0] {
		PIOR_TB_STOP = 3'b000,
		PIOR_TB_SYSCLK = 3'b001,
		PIOR_TB_FAST_RC = 3'b010,
		PIOR_TB_SLOW_RC = 3'b100,
		PIOR_TB_COMP = 3'b101,
		PIOR_TB_XLP_RC = 3'b110
	} pior_tb_clk_t;
endpackage
`default_nettype wire

// ==== src/pior_register_map.sv ====
// Behaviour
// RL1: Comparator, sixteen_bit_timer, pin flags; write zero clears
// RL2: Sixteen_bit_timer clock source decode, reserved stops
// RL3: Sixteen_bit_timer divider 1, 4, 16, 64
// RL4: Sixteen_bit_timer event on selected bit 8-10
// RL5: Sixteen_bit_timer edge bit picks rising or falling
// RL6: Pin and comparator edge: both, rise, fall
// RL7: Input enables gate input, wake, pin interrupts
// RL8: Port data and direction, reset zero
// RL9: Pull-up and pull-down enables, reset zero
// RL10: Wake delay 16 or 8 slow clocks
// RL11: Low-voltage reset on unless disable bit set
// RL12: Watchdog timeout 8k to 256k, shortest at reset
// RL13: Comparator enable, live result, sampling, inversion
// RL14: Comparator minus and plus input selection
// RL15: Comparator pin output, wake, range, level
// RL16: First 8-bit timer clock source decode
// RL17: First timer output pin route and polarity
// RL18: First timer write-only prescaler and scaler
// RL19: First timer counter read-only, bound write-only
// RL20: Second timer clock decode, low-power oscillator enable
// RL21: Second timer scaler and prescaler
// RL22: LPWM fast clock 16 or 32 MHz
// RL23: Reserved bits zero, write-only reads harmless
`timescale 1ns/100ps
`default_nettype none
module pior_register_map
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] ioAddr,
	input wire logic ioWrEn,
	input wire logic [7:0] ioWrData,
	input wire logic ioRdEn,
	output logic [7:0] ioRdData,
	input wire logic compResult,
	input wire logic [2:0] timer16Bits,
	input wire logic [7:0] pinIn,
	input wire logic [7:0] timerACount,
	input wire logic [7:0] timerBCount,
	output logic [7:0] irqFlags,
	output pior_pkg::pior_t16_clk_t t16ClkSrc,
	output logic [2:0] t16DivLog2,
	output logic [7:0] pinInputEn,
	output logic [7:0] portData,
	output logic [7:0] portDir,
	output logic [7:0] portPullUp,
	output logic [7:0] portPullDown,
	output logic [4:0] wakeDelay,
	output logic lvrEnable,
	output logic [18:0] wdtTimeout,
	output logic compEnable,
	output logic compSampleTa,
	output logic compInvert,
	output logic [2:0] compMinusSel,
	output logic compPlusPin,
	output logic compOutToPin,
	output logic compWakeEn,
	output logic compHighRange,
	output logic compLowRange,
	output logic [3:0] compLevel,
	output pior_pkg::pior_ta_clk_t taClkSrc,
	output logic taOutPin3,
	output logic taOutPin4,
	output logic taOutInvert,
	output logic [2:0] taPreLog2,
	output logic [4:0] taScaler,
	output logic [7:0] taBound,
	output pior_pkg::pior_tb_clk_t tbClkSrc,
	output logic tbXlpOscEn,
	output logic [2:0] tbPreLog2,
	output logic [2:0] tbScalerDiv,
	output logic [7:0] tbBound,
	output logic tbCountWr,
	output logic [7:0] tbCountData,
	output logic lpwmFastDouble
);
	import pior_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [7:0] t16Mode;
		logic [7:0] edgeSel;
		logic [7:0] inputEn;
		logic [7:0] paData;
		logic [7:0] paDir;
		logic [7:0] paPullUp;
		logic [7:0] paPullDown;
		logic [7:0] compCtl;
		logic [7:0] compSel;
		logic [7:0] misc;
		logic [7:0] taCtl;
		logic [7:0] taScaler;
		logic [7:0] taBound;
		logic [7:0] tbCtl;
		logic [7:0] tbScaler;
		logic [7:0] tbBound;
		logic [7:0] lpwmLink;
		logic [7:0] irq;
		logic t16Prev;
		logic pinAPrev;
		logic pinBPrev;
		logic compPrev;
		pior_t16_clk_t t16Clk;
		pior_ta_clk_t taClk;
		pior_tb_clk_t tbClk;
		logic [2:0] t16Div;
		logic [2:0] taPre;
		logic [2:0] tbPre;
		logic [2:0] tbDiv;
		logic [4:0] wake;
		logic [18:0] wdt;
		logic [7:0] rdData;
		logic tbWr;
		logic [7:0] tbData;
	} pior_state_t;

	pior_state_t state_ff;
	pior_state_t nxt_state;

	// Each prescaler code steps the division by a factor of four
	function automatic logic [2:0] preLog2(input logic [1:0] code);
		preLog2 = {code, 1'b0};
	endfunction

	function automatic logic edgeHit(input logic [1:0] mode, input logic prev, input logic cur);
		edgeHit = 1'b0;
		case (mode)
			PIOR_EDGE_BOTH: edgeHit = prev ^ cur;
			PIOR_EDGE_RISE: edgeHit = cur & ~prev;
			PIOR_EDGE_FALL: edgeHit = prev & ~cur;
			default: edgeHit = 1'b0;
		endcase
	endfunction

	logic t16Cur;
	logic t16Valid;
	logic t16Event;
	logic pinEvent;
	logic compEvent;
	logic [7:0] portRead;

	// ************************************************************
	// Event detection
	// ************************************************************
	always_comb
	begin
		t16Cur = 1'b0;
		t16Valid = 1'b1;
		case (state_ff.t16Mode[2:0])
			3'h0: t16Cur = timer16Bits[0]; // [RL4]
			3'h1: t16Cur = timer16Bits[1]; // [RL4]
			3'h2: t16Cur = timer16Bits[2]; // [RL4]
			default:
			begin
				t16Cur = 1'b0;
				t16Valid = 1'b0;
			end
		endcase
		if (state_ff.edgeSel[PIOR_EDGE_T16_FALL])
		begin
			t16Event = t16Valid & state_ff.t16Prev & ~t16Cur; // [RL5]
		end
		else
		begin
			t16Event = t16Valid & ~state_ff.t16Prev & t16Cur; // [RL5]
		end
		// A disabled input also hides its interrupt request
		pinEvent = (state_ff.inputEn[PIOR_PIN_A]
			& edgeHit(state_ff.edgeSel[1:0], state_ff.pinAPrev, pinIn[PIOR_PIN_A]))
			| (state_ff.inputEn[PIOR_PIN_B]
			& edgeHit(state_ff.edgeSel[1:0], state_ff.pinBPrev, pinIn[PIOR_PIN_B])); // [RL6] [RL7]
		compEvent = edgeHit(state_ff.edgeSel[7:6], state_ff.compPrev, compResult); // [RL6]
		// Inputs read their pin, outputs read their latch
		portRead = (state_ff.paDir & state_ff.paData)
			| (~state_ff.paDir & pinIn & state_ff.inputEn); // [RL7] [RL8]
	end

	// ************************************************************
	// Register writes and decode
	// ************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.t16Prev = t16Cur;
		nxt_state.pinAPrev = pinIn[PIOR_PIN_A];
		nxt_state.pinBPrev = pinIn[PIOR_PIN_B];
		nxt_state.compPrev = compResult;
		nxt_state.tbWr = 1'b0;
		if (ioWrEn)
		begin
			if (ioAddr == PIOR_OFS_IRQ_FLAGS)
			begin
				nxt_state.irq = state_ff.irq & ioWrData & PIOR_MASK_IRQ; // [RL1]
			end
			else if (ioAddr == PIOR_OFS_T16_MODE)
			begin
				nxt_state.t16Mode = ioWrData;
			end
			else if (ioAddr == PIOR_OFS_TA_BOUND)
			begin
				nxt_state.taBound = ioWrData; // [RL19]
			end
			else if (ioAddr == PIOR_OFS_EDGE_SEL)
			begin
				nxt_state.edgeSel = ioWrData & PIOR_MASK_EDGE_SEL; // [RL23]
			end
			else if (ioAddr == PIOR_OFS_PA_INPUT_EN)
			begin
				nxt_state.inputEn = ioWrData & PIOR_MASK_PA_INPUT_EN; // [RL7]
			end
			else if (ioAddr == PIOR_OFS_PA_DATA)
			begin
				nxt_state.paData = ioWrData; // [RL8]
			end
			else if (ioAddr == PIOR_OFS_PA_DIR)
			begin
				nxt_state.paDir = ioWrData; // [RL8]
			end
			else if (ioAddr == PIOR_OFS_PA_PULL_UP)
			begin
				nxt_state.paPullUp = ioWrData; // [RL9]
			end
			else if (ioAddr == PIOR_OFS_PA_PULL_DOWN)
			begin
				nxt_state.paPullDown = ioWrData; // [RL9]
			end
			else if (ioAddr == PIOR_OFS_TA_SCALER)
			begin
				nxt_state.taScaler = ioWrData & PIOR_MASK_TA_SCALER; // [RL18]
			end
			else if (ioAddr == PIOR_OFS_COMP_CTL)
			begin
				nxt_state.compCtl = ioWrData & PIOR_MASK_COMP_CTL; // [RL13]
			end
			else if (ioAddr == PIOR_OFS_MISC)
			begin
				nxt_state.misc = ioWrData & PIOR_MASK_MISC; // [RL23]
			end
			else if (ioAddr == PIOR_OFS_TA_CTL)
			begin
				nxt_state.taCtl = ioWrData & PIOR_MASK_TA_CTL; // [RL23]
			end
			else if (ioAddr == PIOR_OFS_COMP_SEL)
			begin
				nxt_state.compSel = ioWrData; // [RL15]
			end
			else if (ioAddr == PIOR_OFS_TB_CTL)
			begin
				nxt_state.tbCtl = ioWrData & PIOR_MASK_TB_CTL; // [RL20]
			end
			else if (ioAddr == PIOR_OFS_TB_COUNT)
			begin
				// The counter itself lives in the timer; hand it the load
				nxt_state.tbWr = 1'b1;
				nxt_state.tbData = ioWrData;
			end
			else if (ioAddr == PIOR_OFS_TB_SCALER)
			begin
				nxt_state.tbScaler = ioWrData & PIOR_MASK_TB_SCALER; // [RL21]
			end
			else if (ioAddr == PIOR_OFS_TB_BOUND)
			begin
				nxt_state.tbBound = ioWrData;
			end
			else if (ioAddr == PIOR_OFS_LPWM_LINK)
			begin
				nxt_state.lpwmLink = ioWrData & PIOR_MASK_LPWM_LINK; // [RL22]
			end
		end
		// A hardware event in the clearing cycle still lands
		nxt_state.irq[PIOR_IRQ_T16] = nxt_state.irq[PIOR_IRQ_T16] | t16Event; // [RL1]
		nxt_state.irq[PIOR_IRQ_PIN] = nxt_state.irq[PIOR_IRQ_PIN] | pinEvent; // [RL1]
		nxt_state.irq[PIOR_IRQ_COMP] = nxt_state.irq[PIOR_IRQ_COMP] | compEvent; // [RL1]

		// Reserved clock codes decode to stop so nothing runs on them
		case (nxt_state.t16Mode[7:5])
			PIOR_T16_SYSCLK: nxt_state.t16Clk = PIOR_T16_SYSCLK; // [RL2]
			PIOR_T16_PA4_FALL: nxt_state.t16Clk = PIOR_T16_PA4_FALL; // [RL2]
			PIOR_T16_FAST_RC: nxt_state.t16Clk = PIOR_T16_FAST_RC; // [RL2]
			PIOR_T16_SLOW_RC: nxt_state.t16Clk = PIOR_T16_SLOW_RC; // [RL2]
			PIOR_T16_PA0_FALL: nxt_state.t16Clk = PIOR_T16_PA0_FALL; // [RL2]
			default: nxt_state.t16Clk = PIOR_T16_STOP;
		endcase
		nxt_state.t16Div = preLog2(nxt_state.t16Mode[4:3]); // [RL3]
		case (nxt_state.taCtl[7:4])
			PIOR_TA_SYSCLK: nxt_state.taClk = PIOR_TA_SYSCLK; // [RL16]
			PIOR_TA_FAST_RC: nxt_state.taClk = PIOR_TA_FAST_RC; // [RL16]
			PIOR_TA_SLOW_RC: nxt_state.taClk = PIOR_TA_SLOW_RC; // [RL16]
			PIOR_TA_COMP: nxt_state.taClk = PIOR_TA_COMP; // [RL16]
			PIOR_TA_PA0_RISE: nxt_state.taClk = PIOR_TA_PA0_RISE; // [RL16]
			PIOR_TA_PA0_FALL: nxt_state.taClk = PIOR_TA_PA0_FALL; // [RL16]
			PIOR_TA_PA4_INV: nxt_state.taClk = PIOR_TA_PA4_INV; // [RL16]
			default: nxt_state.taClk = PIOR_TA_STOP;
		endcase
		nxt_state.taPre = preLog2(nxt_state.taScaler[6:5]); // [RL18]
		case (nxt_state.tbCtl[6:4])
			PIOR_TB_SYSCLK: nxt_state.tbClk = PIOR_TB_SYSCLK; // [RL20]
			PIOR_TB_FAST_RC: nxt_state.tbClk = PIOR_TB_FAST_RC; // [RL20]
			PIOR_TB_SLOW_RC: nxt_state.tbClk = PIOR_TB_SLOW_RC; // [RL20]
			PIOR_TB_COMP: nxt_state.tbClk = PIOR_TB_COMP; // [RL20]
			PIOR_TB_XLP_RC: nxt_state.tbClk = PIOR_TB_XLP_RC; // [RL20]
			default: nxt_state.tbClk = PIOR_TB_STOP;
		endcase
		nxt_state.tbPre = preLog2(nxt_state.tbScaler[6:5]); // [RL21]
		case (nxt_state.tbScaler[1:0])
			2'b01: nxt_state.tbDiv = 3'h2; // [RL21]
			2'b11: nxt_state.tbDiv = 3'h4; // [RL21]
			default: nxt_state.tbDiv = 3'h1;
		endcase
		nxt_state.wake = nxt_state.misc[PIOR_MISC_FAST_WAKE] ? PIOR_WAKE_FAST
			: PIOR_WAKE_NORMAL; // [RL10]
		case (nxt_state.misc[1:0])
			2'b00: nxt_state.wdt = PIOR_WDT_8K; // [RL12]
			2'b01: nxt_state.wdt = PIOR_WDT_16K; // [RL12]
			2'b10: nxt_state.wdt = PIOR_WDT_64K; // [RL12]
			default: nxt_state.wdt = PIOR_WDT_256K; // [RL12]
		endcase

		// ************************************************************
		// Register reads
		// ************************************************************
		// Write-only registers and holes read zero with no side effect
		nxt_state.rdData = state_ff.rdData;
		if (ioRdEn)
		begin
			if (ioAddr == PIOR_OFS_IRQ_FLAGS)
			begin
				nxt_state.rdData = state_ff.irq; // [RL1]
			end
			else if (ioAddr == PIOR_OFS_T16_MODE)
			begin
				nxt_state.rdData = state_ff.t16Mode;
			end
			else if (ioAddr == PIOR_OFS_PA_DATA)
			begin
				nxt_state.rdData = portRead; // [RL8]
			end
			else if (ioAddr == PIOR_OFS_PA_DIR)
			begin
				nxt_state.rdData = state_ff.paDir;
			end
			else if (ioAddr == PIOR_OFS_PA_PULL_UP)
			begin
				nxt_state.rdData = state_ff.paPullUp;
			end
			else if (ioAddr == PIOR_OFS_PA_PULL_DOWN)
			begin
				nxt_state.rdData = state_ff.paPullDown;
			end
			else if (ioAddr == PIOR_OFS_COMP_CTL)
			begin
				nxt_state.rdData = state_ff.compCtl;
				nxt_state.rdData[PIOR_COMP_RESULT] = compResult; // [RL13]
			end
			else if (ioAddr == PIOR_OFS_TA_CTL)
			begin
				nxt_state.rdData = state_ff.taCtl;
			end
			else if (ioAddr == PIOR_OFS_TA_COUNT)
			begin
				nxt_state.rdData = timerACount; // [RL19]
			end
			else if (ioAddr == PIOR_OFS_TB_CTL)
			begin
				nxt_state.rdData = state_ff.tbCtl;
			end
			else if (ioAddr == PIOR_OFS_TB_COUNT)
			begin
				nxt_state.rdData = timerBCount;
			end
			else
			begin
				nxt_state.rdData = PIOR_RST_ZERO; // [RL23]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= '0;
			state_ff.inputEn <= PIOR_RST_PA_INPUT_EN; // [RL7]
			state_ff.t16Clk <= PIOR_T16_STOP;
			state_ff.taClk <= PIOR_TA_STOP;
			state_ff.tbClk <= PIOR_TB_STOP;
			state_ff.tbDiv <= 3'h1;
			state_ff.wake <= PIOR_WAKE_NORMAL; // [RL10]
			state_ff.wdt <= PIOR_WDT_8K; // [RL12]
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign ioRdData = state_ff.rdData;
	assign irqFlags = state_ff.irq;
	assign t16ClkSrc = state_ff.t16Clk;
	assign t16DivLog2 = state_ff.t16Div;
	assign pinInputEn = state_ff.inputEn;
	assign portData = state_ff.paData;
	assign portDir = state_ff.paDir;
	assign portPullUp = state_ff.paPullUp;
	assign portPullDown = state_ff.paPullDown;
	assign wakeDelay = state_ff.wake;
	assign lvrEnable = ~state_ff.misc[PIOR_MISC_LVR_OFF]; // [RL11]
	assign wdtTimeout = state_ff.wdt;
	assign compEnable = state_ff.compCtl[7]; // [RL13]
	assign compSampleTa = state_ff.compCtl[5]; // [RL13]
	assign compInvert = state_ff.compCtl[4]; // [RL13]
	assign compMinusSel = state_ff.compCtl[3:1]; // [RL14]
	assign compPlusPin = state_ff.compCtl[0]; // [RL14]
	assign compOutToPin = state_ff.compSel[7]; // [RL15]
	assign compWakeEn = state_ff.compSel[6]; // [RL15]
	assign compHighRange = state_ff.compSel[5]; // [RL15]
	assign compLowRange = state_ff.compSel[4]; // [RL15]
	assign compLevel = state_ff.compSel[3:0]; // [RL15]
	assign taClkSrc = state_ff.taClk;
	assign taOutPin3 = state_ff.taCtl[3:2] == 2'b10; // [RL17]
	assign taOutPin4 = state_ff.taCtl[3:2] == 2'b11; // [RL17]
	assign taOutInvert = state_ff.taCtl[0]; // [RL17]
	assign taPreLog2 = state_ff.taPre;
	assign taScaler = state_ff.taScaler[4:0]; // [RL18]
	assign taBound = state_ff.taBound;
	assign tbClkSrc = state_ff.tbClk;
	assign tbXlpOscEn = state_ff.tbCtl[0]; // [RL20]
	assign tbPreLog2 = state_ff.tbPre;
	assign tbScalerDiv = state_ff.tbDiv;
	assign tbBound = state_ff.tbBound;
	assign tbCountWr = state_ff.tbWr;
	assign tbCountData = state_ff.tbData;
	assign lpwmFastDouble = state_ff.lpwmLink[PIOR_LPWM_FAST_DOUBLE]; // [RL22]
endmodule
`default_nettype wire

// ==== testbench/pior_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pior_core_model
(
	input wire logic clk,
	output logic [5:0] ioAddr,
	output logic ioWrEn,
	output logic [7:0] ioWrData,
	output logic ioRdEn,
	input wire logic [7:0] ioRdData
);
	// ****************************************
	// Core side of the I/O move instructions
	// ****************************************
	initial
	begin
		ioAddr = 6'h00;
		ioWrEn = 1'b0;
		ioWrData = 8'h00;
		ioRdEn = 1'b0;
	end
	// Released lines carry the inverse so a stale value never looks valid
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
	begin
		@(posedge clk);
		ioAddr <= a;
		ioWrData <= d;
		ioWrEn <= 1'b1;
		@(posedge clk);
		ioWrEn <= 1'b0;
		ioAddr <= ~a;
		ioWrData <= ~d;
		#1;
	end
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
	begin
		@(posedge clk);
		ioAddr <= a;
		ioRdEn <= 1'b1;
		@(posedge clk);
		ioRdEn <= 1'b0;
		ioAddr <= ~a;
		#1;
		d = ioRdData;
	end
	endtask
endmodule
`default_nettype wire

// ==== testbench/pior_register_map_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module pior_register_map_monitor
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] ioAddr,
	input wire logic ioWrEn,
	input wire logic [7:0] ioWrData,
	input wire logic ioRdEn,
	input wire logic [7:0] ioRdData,
	input wire logic compResult,
	input wire logic [7:0] timerBCount,
	input wire logic [7:0] irqFlags,
	input wire logic [7:0] pinInputEn,
	input wire logic [7:0] portData,
	input wire logic [7:0] portDir,
	input wire logic [4:0] wakeDelay,
	input wire logic lvrEnable,
	input wire logic [18:0] wdtTimeout
);
	import pior_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_wr(logic [5:0] a); ioWrEn && ioAddr == a; endsequence
	sequence s_rd(logic [5:0] a); ioRdEn && ioAddr == a; endsequence
	// Detector sees the change one edge late
	sequence s_compChg; $past(compResult) != $past(compResult, 2); endsequence
	property p_dataWr; s_wr(PIOR_OFS_PA_DATA) |=> portData == $past(ioWrData); endproperty
	a_dataWr: assert property (p_dataWr) else $error("port data write lost");
	property p_dirRd; s_rd(PIOR_OFS_PA_DIR) ##0 !ioWrEn |=> ioRdData == $past(portDir); endproperty
	a_dirRd: assert property (p_dirRd) else $error("direction read wrong");
	property p_woRd; s_rd(PIOR_OFS_TB_BOUND) |=> ioRdData == 8'h00; endproperty
	a_woRd: assert property (p_woRd) else $error("write-only read not zero");
	property p_cntRd; s_rd(PIOR_OFS_TB_COUNT) |=> ioRdData == $past(timerBCount); endproperty
	a_cntRd: assert property (p_cntRd) else $error("counter read wrong");
	property p_lvr; s_wr(PIOR_OFS_MISC) |=> lvrEnable == !$past(ioWrData[2]); endproperty
	a_lvr: assert property (p_lvr) else $error("low voltage reset enable wrong");
	property p_wake;
		s_wr(PIOR_OFS_MISC) |=>
			wakeDelay == ($past(ioWrData[5]) ? PIOR_WAKE_FAST : PIOR_WAKE_NORMAL);
	endproperty
	a_wake: assert property (p_wake) else $error("wake delay wrong");
	property p_wdt; s_wr(PIOR_OFS_MISC) ##0 ioWrData[1:0] == 2'b11 |=> wdtTimeout == PIOR_WDT_256K;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog timeout wrong");
	property p_flagSet; $rose(irqFlags[PIOR_IRQ_COMP]) |-> s_compChg; endproperty
	a_flagSet: assert property (p_flagSet) else $error("comparator flag without edge");
	property p_flagClr;
		s_wr(PIOR_OFS_IRQ_FLAGS) ##0 !ioWrData[4] ##0 $stable(compResult) |=> !irqFlags[4];
	endproperty
	a_flagClr: assert property (p_flagClr) else $error("flag not cleared");
	property p_flagHold; irqFlags[4] && !(ioWrEn && ioAddr == PIOR_OFS_IRQ_FLAGS) |=> irqFlags[4];
	endproperty
	a_flagHold: assert property (p_flagHold) else $error("flag dropped");
	property p_enRst; $rose(reset_n) |-> pinInputEn == PIOR_RST_PA_INPUT_EN; endproperty
	a_enRst: assert property (p_enRst) else $error("input enable reset wrong");
endmodule
bind pior_register_map pior_register_map_monitor mon_u (.clk(clk), .reset_n(reset_n),
	.ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioWrData(ioWrData), .ioRdEn(ioRdEn),
	.ioRdData(ioRdData), .compResult(compResult), .timerBCount(timerBCount),
	.irqFlags(irqFlags), .pinInputEn(pinInputEn), .portData(portData), .portDir(portDir),
	.wakeDelay(wakeDelay), .lvrEnable(lvrEnable), .wdtTimeout(wdtTimeout));
`default_nettype wire

// ==== testbench/pior_register_map_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pior_register_map_tb_top;
	import pior_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic compResult = 1'b0;
	logic [2:0] timer16Bits = 3'h0;
	logic [7:0] pinIn = 8'h00;
	logic [7:0] timerBCount = 8'h3C;
	logic [5:0] ioAddr;
	logic ioWrEn;
	logic ioRdEn;
	logic [7:0] ioWrData;
	logic [7:0] ioRdData;
	logic [7:0] irqFlags;
	logic [7:0] pinInputEn;
	logic [7:0] portData;
	logic [4:0] wakeDelay;
	logic lvrEnable;
	logic [18:0] wdtTimeout;
	pior_t16_clk_t t16ClkSrc;
	pior_ta_clk_t taClkSrc;
	pior_tb_clk_t tbClkSrc;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [5:0] regA [19] = '{PIOR_OFS_T16_MODE, PIOR_OFS_PA_DIR, PIOR_OFS_PA_DATA,
		PIOR_OFS_PA_PULL_UP, PIOR_OFS_PA_PULL_DOWN, PIOR_OFS_TA_CTL, PIOR_OFS_TB_CTL,
		PIOR_OFS_COMP_CTL, PIOR_OFS_TB_COUNT, PIOR_OFS_TA_BOUND, PIOR_OFS_EDGE_SEL,
		PIOR_OFS_PA_INPUT_EN, PIOR_OFS_TA_SCALER, PIOR_OFS_MISC, PIOR_OFS_COMP_SEL,
		PIOR_OFS_TB_SCALER, PIOR_OFS_TB_BOUND, PIOR_OFS_LPWM_LINK, 6'h3F};
	logic [7:0] regE [19] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, PIOR_MASK_TA_CTL,
		PIOR_MASK_TB_CTL, PIOR_MASK_COMP_CTL, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #5 clk = ~clk;
	pior_core_model core_u (.clk(clk), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
		.ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdData(ioRdData));
	pior_register_map dut_u (.clk(clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
		.ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdData(ioRdData), .compResult(compResult),
		.timer16Bits(timer16Bits), .pinIn(pinIn), .timerACount(8'h00),
		.timerBCount(timerBCount), .irqFlags(irqFlags), .t16ClkSrc(t16ClkSrc),
		.t16DivLog2(), .pinInputEn(pinInputEn), .portData(portData), .portDir(),
		.portPullUp(), .portPullDown(), .wakeDelay(wakeDelay), .lvrEnable(lvrEnable),
		.wdtTimeout(wdtTimeout), .compEnable(), .compSampleTa(), .compInvert(),
		.compMinusSel(), .compPlusPin(), .compOutToPin(), .compWakeEn(), .compHighRange(),
		.compLowRange(), .compLevel(), .taClkSrc(taClkSrc), .taOutPin3(),
		.taOutPin4(), .taOutInvert(), .taPreLog2(), .taScaler(), .taBound(),
		.tbClkSrc(tbClkSrc), .tbXlpOscEn(), .tbPreLog2(), .tbScalerDiv(),
		.tbBound(), .tbCountWr(), .tbCountData(), .lpwmFastDouble());
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk(input logic [18:0] g, input logic [18:0] e);
	begin
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
	begin
		core_u.rd(a, d);
		chk(d, e);
	end
	endtask
	// Toggles one event source and checks its flag: 0 comparator, 1 pin, 2 timer bit
	task automatic tog(input int s, input int m, input logic en);
		logic v;
		int b;
	begin
		b = (s == 0) ? 4 : (s == 1) ? 0 : 2;
		core_u.wr(PIOR_OFS_IRQ_FLAGS, 8'h00);
		v = ~((s == 0) ? compResult : (s == 1) ? pinIn[0] : timer16Bits[1]);
		@(posedge clk);
		if (s == 0)
			compResult <= v;
		else if (s == 1)
			pinIn[0] <= v;
		else
			timer16Bits[1] <= v;
		@(posedge clk);
		#1;
		chk(irqFlags[b], en && (s == 2 ? v ^ m[0] : m == 0 || (m == 1 && v) || (m == 2 && !v)));
	end
	endtask
	task automatic stop_test;
	begin
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_errors++;
			stop_test();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk(pinInputEn, 8'hF9);
		chk(wakeDelay, 5'h10);
		chk(lvrEnable, 1'b1);
		chk(wdtTimeout, 19'h02000);
		for (int i = 0; i < 19; i++)
			rdc(regA[i], (i == 8) ? 8'h3C : 8'h00);
		for (int i = 0; i < 19; i++)
		begin
			core_u.wr(regA[i], 8'hFF);
			rdc(regA[i], regE[i]);
		end
		core_u.wr(PIOR_OFS_IRQ_FLAGS, 8'hFF);
		rdc(PIOR_OFS_IRQ_FLAGS, 8'h00);
		chk({dut_u.taOutPin3, dut_u.taOutPin4, dut_u.taScaler, dut_u.compMinusSel,
			dut_u.lpwmFastDouble}, 11'h3FF);
		for (int i = 0; i < 16; i++)
		begin
			core_u.wr(PIOR_OFS_TA_CTL, {i[3:0], 4'h0});
			chk(taClkSrc, (i inside {0, 1, 2, 4, 5, 8, 9, 13}) ? i : 0);
			if (i < 8)
			begin
				core_u.wr(PIOR_OFS_T16_MODE, {i[2:0], i[1:0], 3'h0});
				chk(t16ClkSrc, (i inside {0, 1, 3, 4, 6, 7}) ? i : 0);
				chk(dut_u.t16DivLog2, 2 * (i % 4));
				core_u.wr(PIOR_OFS_TB_CTL, {1'b0, i[2:0], 4'h0});
				chk(tbClkSrc, (i inside {0, 1, 2, 4, 5, 6}) ? i : 0);
			end
			if (i < 4)
			begin
				core_u.wr(PIOR_OFS_TB_SCALER, {6'h00, i[1:0]});
				chk(dut_u.tbScalerDiv, (i == 3) ? 4 : (i == 1) ? 2 : 1);
				core_u.wr(PIOR_OFS_MISC, {2'b00, i[0], 2'b00, i[1], i[1:0]});
				chk(wakeDelay, i[0] ? 8 : 16);
				chk(lvrEnable, !i[1]);
				chk(wdtTimeout, 19'h02000 << (2 * i - (i > 0)));
			end
		end
		core_u.wr(PIOR_OFS_COMP_SEL, 8'h5C);
		chk(dut_u.compLevel, 4'hC);
		core_u.wr(PIOR_OFS_PA_DIR, 8'h0F);
		core_u.wr(PIOR_OFS_PA_DATA, 8'hA5);
		chk(portData, 8'hA5);
		@(posedge clk);
		pinIn <= 8'h3C;
		rdc(PIOR_OFS_PA_DATA, 8'h35);
		core_u.wr(PIOR_OFS_PA_INPUT_EN, 8'h00);
		rdc(PIOR_OFS_PA_DATA, 8'h05);
		core_u.wr(PIOR_OFS_PA_INPUT_EN, 8'hFF);
		@(posedge clk);
		compResult <= 1'b1;
		rdc(PIOR_OFS_COMP_CTL, 8'hFF);
		core_u.wr(PIOR_OFS_T16_MODE, 8'h01);
		for (int m = 0; m < 4; m++)
		begin
			core_u.wr(PIOR_OFS_EDGE_SEL, {m[1:0], 1'b0, m[0], 2'b00, m[1:0]});
			for (int s = 0; s < 3; s++)
				repeat (2) tog(s, m, 1'b1);
		end
		core_u.wr(PIOR_OFS_EDGE_SEL, 8'h00);
		core_u.wr(PIOR_OFS_PA_INPUT_EN, 8'h00);
		tog(1, 0, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
